// ==== hw/cmsf_fifo.sv ====
/*
 memory-mapped write slave to streaming source fifo, single or dual clock.
 assumes a master without bursts on the input and a sink with ready latency one on the output;
 in dual clock builds mclk is the write clock and rd_clk the read clock.
*/
`timescale 1ns/10ps
`include "cmsf_consts.svh"

// What this block does
// - words leave in exactly the order they were accepted
// - no bursts: each input access moves one word, each output beat one word
// - built with one shared clock or separate write and read clocks
// - streaming source drives valid data one cycle after sink ready
// - waitrequest held on write to full buffer until room exists
// - streaming ports use ready and valid for space and data
// - symbol bits, symbols per beat, error and channel widths are parameters
// - mm write to streaming output takes 32-bit words in, SYM_BITS*SYMS bits per output beat
// - symbols reordered so byte order fits the streaming protocol
// - waitrequest whenever there is not room to finish the write
// - without packets each write to offset 0 enqueues one word
// - write to offset 1 updates held packet status, enqueues nothing
// - write to offset 0 enqueues data plus the held packet status
// - held status persists across data writes until rewritten
// - empty counts unused symbols, these sit in the low symbol slots
// - single clock build always carries both fill level ports, in_fill_level and out_fill_level
// - dual clock build may carry a status port per side
// - input logic on write clock, output logic on read clock
// - dual clock usable capacity is depth minus three
module cmsf_fifo import cmsf_pkg::*; #(
	parameter int DEPTH = `CMSF_DEPTH,
	parameter int SYM_BITS = `CMSF_SYM_BITS,
	parameter int SYMS = `CMSF_SYMS,
	parameter int CHAN_W = `CMSF_ST_CHAN_W,
	parameter int ERR_W = `CMSF_ST_ERR_W,
	parameter bit DUAL_CLOCK = 1'b0,
	parameter bit PACKET_EN = 1'b1,
	parameter bit BACKPRESSURE = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic rd_clk,
	input wire logic rd_rst_n,
	input wire logic in_write,
	input wire logic in_address,
	input wire logic [`CMSF_WORD_W-1:0] in_writedata,
	output logic in_waitrequest,
	output logic [SYM_BITS*SYMS-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic out_startofpacket,
	output logic out_endofpacket,
	output logic [`CMSF_ST_EMPTY_W-1:0] out_empty,
	output logic [CHAN_W-1:0] out_channel,
	output logic [ERR_W-1:0] out_error,
	output logic [$clog2(DEPTH):0] in_fill_level,
	output logic [$clog2(DEPTH):0] out_fill_level
);

	// ----------------------------------------
	// local sizes
	// ----------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int CAP = DUAL_CLOCK ? DEPTH - `CMSF_DC_RESERVE : DEPTH;
	localparam int DW = SYM_BITS * SYMS;
	localparam logic [PW-1:0] CAP_P = PW'(CAP);

	logic rclk;
	logic rrst_n;
	assign rclk = DUAL_CLOCK ? rd_clk : mclk;
	assign rrst_n = DUAL_CLOCK ? rd_rst_n : rst_n;

	function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = g;
		for (int i = PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction : gray2bin

	// ----------------------------------------
	// storage
	// ----------------------------------------
	cmsf_entry_t mem [DEPTH];
	cmsf_status_t status_r;
	logic [PW-1:0] wptr_r;
	logic [PW-1:0] wgray_r;
	logic [PW-1:0] rptr_r;
	logic [PW-1:0] rgray_r;
	logic [PW-1:0] rgray_s1_r;
	logic [PW-1:0] rgray_s2_r;
	logic [PW-1:0] wgray_s1_r;
	logic [PW-1:0] wgray_s2_r;
	logic [PW-1:0] rptr_w;
	logic [PW-1:0] wptr_rd;
	logic [PW-1:0] wfill;
	logic [PW-1:0] rfill;
	logic push;
	logic pop;
	logic wfull;
	logic rempty;

	// ----------------------------------------
	// pointer crossing
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rgray_s1_r <= '0;
			rgray_s2_r <= '0;
		end else begin
			rgray_s1_r <= rgray_r;
			rgray_s2_r <= rgray_s1_r;
		end
	end

	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			wgray_s1_r <= '0;
			wgray_s2_r <= '0;
		end else begin
			wgray_s1_r <= wgray_r;
			wgray_s2_r <= wgray_s1_r;
		end
	end

	assign rptr_w = DUAL_CLOCK ? gray2bin(rgray_s2_r) : rptr_r;
	assign wptr_rd = DUAL_CLOCK ? gray2bin(wgray_s2_r) : wptr_r;
	assign wfill = wptr_r - rptr_w;
	assign rfill = wptr_rd - rptr_r;
	assign wfull = wfill >= CAP_P;
	assign rempty = rfill == '0;

	// ----------------------------------------
	// input side: write slave
	// ----------------------------------------
	// waitrequest is combinational to the full state so a stalled write stays
	// stalled exactly until room opens
	assign in_waitrequest = BACKPRESSURE && in_write
		&& (!PACKET_EN || in_address == `CMSF_OFS_PUSH_DATA) && wfull;
	assign push = in_write && !in_waitrequest && !wfull
		&& (!PACKET_EN || in_address == `CMSF_OFS_PUSH_DATA);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= `CMSF_STATUS_RST;
		end else if (PACKET_EN && in_write && in_address == `CMSF_OFS_PKT_STATUS) begin
			status_r.sop <= in_writedata[`CMSF_ST_SOP_BIT];
			status_r.eop <= in_writedata[`CMSF_ST_EOP_BIT];
			status_r.empty <= in_writedata[`CMSF_ST_EMPTY_LSB +: `CMSF_ST_EMPTY_W];
			status_r.chan <= in_writedata[`CMSF_ST_CHAN_LSB +: `CMSF_ST_CHAN_W];
			status_r.err <= in_writedata[`CMSF_ST_ERR_LSB +: `CMSF_ST_ERR_W];
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wptr_r[AW-1:0]].data <= in_writedata;
			mem[wptr_r[AW-1:0]].status <= PACKET_EN ? status_r : '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= '0;
			wgray_r <= '0;
			in_fill_level <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
				wgray_r <= bin2gray(wptr_r + 1'b1);
			end
			in_fill_level <= wfill;
		end
	end

	// ----------------------------------------
	// output side: streaming source
	// ----------------------------------------
	// ready latency one: a beat goes out the cycle after ready was seen
	cmsf_entry_t head;
	logic [DW-1:0] swapped;
	assign head = mem[rptr_r[AW-1:0]];
	assign pop = out_ready && !rempty;

	// first symbol on the wire is the bottom symbol of the word
	genvar gi;
	generate
		for (gi = 0; gi < SYMS; gi++) begin : g_swap
			assign swapped[gi*SYM_BITS +: SYM_BITS] =
				head.data[(SYMS-1-gi)*SYM_BITS +: SYM_BITS];
		end
	endgenerate

	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
			out_startofpacket <= 1'b0;
			out_endofpacket <= 1'b0;
			out_empty <= '0;
			out_channel <= '0;
			out_error <= '0;
			rptr_r <= '0;
			rgray_r <= '0;
			out_fill_level <= '0;
		end else begin
			out_valid <= pop;
			out_fill_level <= rfill;
			if (pop) begin
				out_data <= swapped;
				out_startofpacket <= head.status.sop;
				out_endofpacket <= head.status.eop;
				out_empty <= head.status.empty;
				out_channel <= CHAN_W'(head.status.chan);
				out_error <= ERR_W'(head.status.err);
				rptr_r <= rptr_r + 1'b1;
				rgray_r <= bin2gray(rptr_r + 1'b1);
			end
		end
	end

endmodule : cmsf_fifo

// ==== hw/cmsf_consts.svh ====
/*
 consts for the configurable fifo: register offsets, status field positions, reset values.
 assumes inclusion by bare name from the package and the top module.
*/
`ifndef CMSF_CONSTS_SVH
`define CMSF_CONSTS_SVH

// ----------------------------------------
// register offsets (word index on the input port)
// ----------------------------------------
`define CMSF_OFS_PUSH_DATA 1'h0
`define CMSF_OFS_PKT_STATUS 1'h1

// ----------------------------------------
// packet status word field positions
// ----------------------------------------
`define CMSF_ST_SOP_BIT 0
`define CMSF_ST_EOP_BIT 1
`define CMSF_ST_EMPTY_LSB 2
`define CMSF_ST_EMPTY_W 2
`define CMSF_ST_CHAN_LSB 8
`define CMSF_ST_CHAN_W 5
`define CMSF_ST_ERR_LSB 16
`define CMSF_ST_ERR_W 3

// ----------------------------------------
// widths, depths, reset values
// ----------------------------------------
`define CMSF_WORD_W 32
`define CMSF_DEPTH 16
`define CMSF_SYM_BITS 8
`define CMSF_SYMS 4
`define CMSF_DC_RESERVE 3
`define CMSF_SYNC_STAGES 2
`define CMSF_STATUS_RST 12'h000

`endif

// ==== hw/cmsf_pkg.sv ====
/*
 types for the configurable fifo: packet status word and stored fifo entry.
 assumes the consts header sits beside it.
*/
`include "cmsf_consts.svh"

package cmsf_pkg;

	// ----------------------------------------
	// packet side information
	// ----------------------------------------
	typedef struct packed {
		logic [`CMSF_ST_ERR_W-1:0] err;
		logic [`CMSF_ST_CHAN_W-1:0] chan;
		logic [`CMSF_ST_EMPTY_W-1:0] empty;
		logic eop;
		logic sop;
	} cmsf_status_t;

	typedef struct packed {
		cmsf_status_t status;
		logic [`CMSF_WORD_W-1:0] data;
	} cmsf_entry_t;

endpackage : cmsf_pkg

// ==== tb/cmsf_fifo_sva.sv ====
/* checker: port assertions for the fifo.
 assumes a single clock build, bound to cmsf_fifo. */
`timescale 1ns/10ps
module cmsf_fifo_chk #(
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_write,
	input wire logic in_address,
	input wire logic in_waitrequest,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic out_endofpacket,
	input wire logic [$clog2(DEPTH):0] in_fill_level
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_status_no_wait: assert property (in_write && in_address |-> !in_waitrequest)
		else $error("status write stalled");
	a_ready_latency: assert property (out_valid |-> $past(out_ready))
		else $error("beat without ready");
	a_beat_stops: assert property (out_valid ##1 !out_ready |=> !out_valid)
		else $error("beat after ready low");
	a_level_bound: assert property (in_fill_level <= DEPTH)
		else $error("level above depth");
	a_wait_full: assert property (in_waitrequest |-> in_fill_level >= DEPTH - 1)
		else $error("stall with room");
	a_push_room: assert property (in_write && !in_address && in_fill_level < DEPTH - 2
		|-> !in_waitrequest)
		else $error("push stalled");
	a_wait_release: assert property (in_waitrequest && out_ready
		|-> ##[1:4] (!in_waitrequest || !in_write))
		else $error("stall not released");
	a_reset_quiet: assert property ($rose(rst_n) |-> !out_valid && !in_waitrequest)
		else $error("busy after reset");
	c_stall: cover property (in_waitrequest);
	c_last_beat: cover property (out_valid && out_endofpacket);
	c_status: cover property (in_write && in_address);
endmodule : cmsf_fifo_chk

bind cmsf_fifo cmsf_fifo_chk #(.DEPTH(DEPTH)) cmsf_fifo_chk_inst (.mclk(mclk), .rst_n(rst_n),
	.in_write(in_write), .in_address(in_address), .in_waitrequest(in_waitrequest),
	.out_valid(out_valid), .out_ready(out_ready), .out_endofpacket(out_endofpacket),
	.in_fill_level(in_fill_level));

// ==== tb/cmsf_sink.sv ====
/* partner: streaming sink giving ready, stalls one cycle in four.
 assumes the bench enables it. */
`timescale 1ns/10ps
module cmsf_sink (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic en,
	output logic out_ready
);
	logic [1:0] ph_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'h1;
			out_ready <= en && ph_r != 2'h3;
		end
	end
endmodule : cmsf_sink

// ==== tb/tb_top.sv ====
/* bench: packet and full-buffer tests, queue based.
 assumes single clock build with default depth. */
`timescale 1ns/10ps
`include "cmsf_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top import cmsf_pkg::*; ;
	logic mclk, rst_n, in_write, in_address, out_valid, out_ready, in_waitrequest, en;
	logic out_startofpacket, out_endofpacket;
	logic [31:0] in_writedata, out_data, st, rs;
	logic [`CMSF_ST_EMPTY_W-1:0] out_empty;
	logic [`CMSF_ST_CHAN_W-1:0] out_channel;
	logic [`CMSF_ST_ERR_W-1:0] out_error;
	logic [4:0] in_fill_level, out_fill_level;
	cmsf_entry_t q[$], ex;
	cmsf_status_t hold;
	int miscompares, cmp_count, cyc;
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	cmsf_fifo cmsf_fifo_inst (.mclk(mclk), .rst_n(rst_n), .rd_clk(mclk), .rd_rst_n(rst_n),
		.in_write(in_write), .in_address(in_address), .in_writedata(in_writedata),
		.in_waitrequest(in_waitrequest), .out_data(out_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_startofpacket(out_startofpacket),
		.out_endofpacket(out_endofpacket), .out_empty(out_empty), .out_channel(out_channel),
		.out_error(out_error), .in_fill_level(in_fill_level),
		.out_fill_level(out_fill_level));
	cmsf_sink cmsf_sink_inst (.mclk(mclk), .rst_n(rst_n), .en(en), .out_ready(out_ready));
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	task close_out();
		$display("counts: %0d compared, %0d mismatched", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic wr(input logic a, input logic [31:0] d);
		int n;
		n = 0;
		in_write <= 1'b1;
		in_address <= a;
		in_writedata <= d;
		@(posedge mclk);
		while (in_waitrequest !== 1'b0 && n < 100) begin
			n++;
			@(posedge mclk);
		end
		if (a) hold = {d[18:16], d[12:8], d[3:2], d[1:0]};
		else q.push_back({hold, d[7:0], d[15:8], d[23:16], d[31:24]});
	endtask : wr
	task automatic drain();
		for (int n = 0; n < 300 && q.size() > 0; n++) @(posedge mclk);
		repeat (3) @(posedge mclk);
	endtask : drain
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
		if (rst_n === 1'b1 && out_valid === 1'b1) begin
			ex = q.size() ? q.pop_front() : 'x;
			`CHK("beat", ex, cmsf_entry_t'({out_error, out_channel, out_empty,
				out_endofpacket, out_startofpacket, out_data}))
		end
	end
	initial begin
		rs = 32'h7f3b;
		rst_n = 1'b0;
		in_write = 1'b0;
		in_address = 1'b0;
		in_writedata = 32'h0;
		en = 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK("valid", 1'b0, out_valid)
		`CHK("wait", 1'b0, in_waitrequest)
		en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			st = rnd() & 32'h0007_1f00 | 32'h1;
			wr(1'b1, st);
			wr(1'b0, rnd());
			wr(1'b0, rnd());
			wr(1'b1, st & ~32'h1 | 32'h2 | (k << 2));
			wr(1'b0, rnd());
		end
		in_write <= 1'b0;
		drain();
		$display("test packets done");
		en <= 1'b0;
		repeat (3) @(posedge mclk);
		for (int k = 0; k < `CMSF_DEPTH; k++) wr(1'b0, rnd());
		st = rnd();
		in_writedata <= st;
		repeat (4) @(posedge mclk);
		`CHK("full wait", 1'b1, in_waitrequest)
		en <= 1'b1;
		wr(1'b0, st);
		in_write <= 1'b0;
		drain();
		`CHK("level", 5'h00, in_fill_level)
		`CHK("out level", 5'h00, out_fill_level)
		$display("test full done");
		close_out();
	end
endmodule : tb_top
